// *** hw/isf_status_flags.sv ***
// status flags, data holding register and software port of the i2c block
//
// Functional notes
// - receiving, new byte while data still unread sets byte done flag.
// - transmitting, empty data register while shift byte goes sets it.
// - byte done clears on status read followed directly by data read or write.
// - start or stop transmitted clears byte done flag.
// - header sent flag sets; status read then data write clears it.
// - stop seen sets flag; status read then control write clears it.
// - rx full flag while data holds received byte; data access clears.
// - tx empty flag while data register holds no pending byte.
// - first written byte moves straight to shift; tx empty sets.
// - writing while the shift register is still full clears tx empty.
// - start or stop transmitted clears tx empty flag.
// - misplaced start or stop sets bus fault flag.
// - arbitration loss sets flag and returns to slave mode.
// - missing acknowledge sets ack fault flag.
// - over/underrun flag sets only while stretch disable is one.
// - slave receiver overrun discards new byte and flags it.
// - slave transmitter underrun resends previous byte and flags it.
// - wakeup from halt sets halt wakeup flag.
// - error flags clear on writing zero; writing one keeps them.
// - all status flags held clear while interface is disabled.
// - error interrupt when enabled and bus, arbitration, ack or over/underrun flag is set.
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
`include "isf_params.svh"

module isf_status_flags
  import isf_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire isf_bus_t    bus,
  output logic      [31:0] rdata,
  input  wire isf_evt_t    evt,
  output logic             tx_load,
  output logic      [7:0]  tx_byte,
  output logic             scl_hold,
  output logic             master_mode,
  output logic             err_irq
);

  // ************************************************************
  // register decode
  // ************************************************************

  // one decode used for read and write side effects; read data uses its own case
  function automatic logic hit(input isf_bus_t b, input logic [7:0] off);
    return b.addr == off;
  endfunction

  logic rd_data, wr_data, rd_xs, wr_err, wr_ctl2, wr_cfg, wr_irq;
  assign rd_data = bus.rd && hit(bus, `ISF_OFF_DATA);
  assign wr_data = bus.wr && hit(bus, `ISF_OFF_DATA);
  assign rd_xs   = bus.rd && hit(bus, `ISF_OFF_XFER_STS);
  assign wr_err  = bus.wr && hit(bus, `ISF_OFF_ERR_STS);
  assign wr_ctl2 = bus.wr && hit(bus, `ISF_OFF_CTRL_TWO);
  assign wr_cfg  = bus.wr && hit(bus, `ISF_OFF_CONFIG);
  assign wr_irq  = bus.wr && hit(bus, `ISF_OFF_IRQ_CTRL);

  // ************************************************************
  // configuration registers
  // ************************************************************

  logic       en_reg, stretch_disable_reg, errie_reg;
  logic [7:0] ctl2_reg;

  // software-owned settings
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      en_reg     <= 1'b0;
      stretch_disable_reg <= 1'b0;
      errie_reg  <= 1'b0;
      ctl2_reg   <= `ISF_RST_BYTE;
    end else begin
      if (wr_cfg) begin
        en_reg     <= bus.wdata[`ISF_CFG_ENABLE];
        stretch_disable_reg <= bus.wdata[`ISF_CFG_STRETCH_DISABLE];
      end
      if (wr_irq) begin
        errie_reg <= bus.wdata[`ISF_IC_ERR_EN];
      end
      if (wr_ctl2) begin
        ctl2_reg <= bus.wdata[7:0];
      end
    end
  end

  // ************************************************************
  // status read then access sequence
  // ************************************************************

  // armed by a status read, spent by the very next access of any kind,
  // so an unrelated access in between breaks the clearing sequence
  logic armed_reg;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      armed_reg <= 1'b0;
    end else if (bus.rd || bus.wr) begin
      armed_reg <= rd_xs && en_reg;
    end
  end

  // ************************************************************
  // data holding register and shift register occupancy
  // ************************************************************

  logic       master_reg, shift_full_reg, pend_full_reg;
  logic [7:0] data_reg, pend_reg;
  logic       rx_full_reg, tx_empty_reg, tx_held_reg;
  logic       ovr_evt, unr_evt, btc_set;

  // slave receiver with stretching off and data still unread
  assign ovr_evt = evt.rx_arrive && rx_full_reg && stretch_disable_reg && !master_reg;
  // slave transmitter asked for a byte that was never written
  assign unr_evt = evt.tx_take && !tx_held_reg && stretch_disable_reg && !master_reg;
  // data unread as a byte arrives, or data empty while shift byte goes
  assign btc_set = (evt.rx_arrive && rx_full_reg && !ovr_evt)
                || (evt.tx_take && !tx_held_reg && !unr_evt);

  // data register, the parked receive byte and the transmit path
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      data_reg       <= `ISF_RST_BYTE;
      pend_reg       <= `ISF_RST_BYTE;
      pend_full_reg  <= 1'b0;
      rx_full_reg    <= 1'b0;
      tx_held_reg    <= 1'b0;
      shift_full_reg <= 1'b0;
      tx_load        <= 1'b0;
      tx_byte        <= `ISF_RST_BYTE;
    end else if (!en_reg) begin
      pend_full_reg  <= 1'b0;
      rx_full_reg    <= 1'b0;
      tx_held_reg    <= 1'b0;
      shift_full_reg <= 1'b0;
      tx_load        <= 1'b0;
    end else begin
      tx_load <= 1'b0;
      if (rd_data || wr_data) begin
        rx_full_reg <= pend_full_reg;
        if (pend_full_reg) begin
          data_reg      <= pend_reg;
          pend_full_reg <= 1'b0;
        end
      end
      if (evt.rx_arrive) begin
        if (!rx_full_reg) begin
          data_reg    <= evt.rx_byte;
          rx_full_reg <= 1'b1;
        end else if (!ovr_evt) begin
          // stretching on or master: byte waits in the shift stage
          pend_reg      <= evt.rx_byte;
          pend_full_reg <= 1'b1;
        end
      end
      if (wr_data) begin
        if (!shift_full_reg || (evt.tx_take && !tx_held_reg)) begin
          tx_byte        <= bus.wdata[7:0];
          tx_load        <= 1'b1;
          shift_full_reg <= 1'b1;
        end else begin
          data_reg    <= bus.wdata[7:0];
          tx_held_reg <= 1'b1;
        end
      end else if (evt.tx_take) begin
        if (tx_held_reg) begin
          tx_byte     <= data_reg;
          tx_load     <= 1'b1;
          tx_held_reg <= 1'b0;
        end else if (unr_evt) begin
          tx_load <= 1'b1;
        end else begin
          shift_full_reg <= 1'b0;
        end
      end
    end
  end

  // ************************************************************
  // transfer_status flags
  // ************************************************************

  logic btc_reg, hdr10_reg, stop_reg;
  logic btc_clr, hdr10_clr, stop_clr;

  assign btc_clr   = armed_reg && (rd_data || wr_data);
  assign hdr10_clr = armed_reg && wr_data;
  assign stop_clr  = armed_reg && wr_ctl2;

  // each flag: set beats the software clear in the same cycle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      btc_reg   <= 1'b0;
      hdr10_reg <= 1'b0;
      stop_reg  <= 1'b0;
    end else if (!en_reg) begin
      btc_reg   <= 1'b0;
      hdr10_reg <= 1'b0;
      stop_reg  <= 1'b0;
    end else begin
      if (btc_set) begin
        btc_reg <= 1'b1;
      end else if (btc_clr || evt.start_sent || evt.stop_sent) begin
        btc_reg <= 1'b0;
      end
      if (evt.hdr10_sent) begin
        hdr10_reg <= 1'b1;
      end else if (hdr10_clr) begin
        hdr10_reg <= 1'b0;
      end
      if (evt.stop_detected) begin
        stop_reg <= 1'b1;
      end else if (stop_clr) begin
        stop_reg <= 1'b0;
      end
    end
  end

  // tx empty follows the data register, but start or stop forces it low
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tx_empty_reg <= 1'b0;
    end else if (!en_reg) begin
      tx_empty_reg <= 1'b0;
    end else if (evt.start_sent || evt.stop_sent) begin
      tx_empty_reg <= 1'b0;
    end else if (wr_data && shift_full_reg
                 && !(evt.tx_take && !tx_held_reg)) begin
      tx_empty_reg <= 1'b0;
    end else if (wr_data || evt.tx_take) begin
      tx_empty_reg <= 1'b1;
    end
  end

  // ************************************************************
  // error_status flags and master state
  // ************************************************************

  logic [5:0] err_reg, err_set, err_keep;

  always_comb begin
    err_set = `ISF_RST_ERR;
    err_set[`ISF_ES_BUS_FAULT] = evt.bus_misplaced;
    err_set[`ISF_ES_ARB_LOST]  = evt.arb_lost && master_reg;
    err_set[`ISF_ES_ACK_FAULT] = evt.ack_missing;
    err_set[`ISF_ES_OVR_UNR]   = ovr_evt || unr_evt;
    err_set[`ISF_ES_HALT_WAKE] = evt.halt_wakeup;
  end

  assign err_keep = wr_err ? bus.wdata[5:0] : 6'h3F;

  // reserved bit 4 never set, so it always reads zero
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      err_reg <= `ISF_RST_ERR;
    end else if (!en_reg) begin
      err_reg <= `ISF_RST_ERR;
    end else begin
      err_reg <= (err_reg & err_keep) | err_set;
    end
  end

  // master after a sent start; arbitration loss drops back to slave
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      master_reg <= 1'b0;
    end else if (!en_reg || evt.arb_lost || evt.stop_sent) begin
      master_reg <= 1'b0;
    end else if (evt.start_sent) begin
      master_reg <= 1'b1;
    end
  end

  assign master_mode = master_reg;
  // stretch SCL while byte done is set, unless stretching is disabled
  assign scl_hold    = btc_reg && !stretch_disable_reg;

  assign err_irq = errie_reg && (err_reg[`ISF_ES_BUS_FAULT]
                 || err_reg[`ISF_ES_ARB_LOST] || err_reg[`ISF_ES_ACK_FAULT]
                 || err_reg[`ISF_ES_OVR_UNR]);

  // ************************************************************
  // read data, one cycle after the strobe
  // ************************************************************

  logic [31:0] rd_next;

  always_comb begin
    rd_next = `ISF_RST_WORD;
    case (bus.addr)
      `ISF_OFF_CONFIG: begin
        rd_next[`ISF_CFG_ENABLE] = en_reg;
        rd_next[`ISF_CFG_STRETCH_DISABLE] = stretch_disable_reg;
      end
      `ISF_OFF_CTRL_TWO: rd_next[7:0] = ctl2_reg;
      `ISF_OFF_DATA:     rd_next[7:0] = data_reg;
      `ISF_OFF_XFER_STS: begin
        rd_next[`ISF_XS_BYTE_DONE] = btc_reg;
        rd_next[`ISF_XS_HDR10]     = hdr10_reg;
        rd_next[`ISF_XS_STOP_SEEN] = stop_reg;
        rd_next[`ISF_XS_RX_FULL]   = rx_full_reg;
        rd_next[`ISF_XS_TX_EMPTY]  = tx_empty_reg;
      end
      `ISF_OFF_ERR_STS:  rd_next[5:0] = err_reg;
      `ISF_OFF_IRQ_CTRL: rd_next[`ISF_IC_ERR_EN] = errie_reg;
      default:           rd_next = `ISF_RST_WORD;
    endcase
  end

  // data stand only in the cycle after the read strobe
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= `ISF_RST_WORD;
    end else begin
      rdata <= bus.rd ? rd_next : `ISF_RST_WORD;
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  byte_done_set_a: assert property (
    en_reg && evt.rx_arrive && rx_full_reg && !stretch_disable_reg |=> btc_reg)
    else $error("byte done not set on unread data");
  byte_done_clr_a: assert property (
    btc_reg && !btc_set && en_reg && armed_reg && rd_data |=> !btc_reg)
    else $error("byte done not cleared by sequence");
  byte_done_keep_a: assert property (
    btc_reg && !armed_reg && !evt.start_sent && !evt.stop_sent
    && en_reg && !wr_cfg |=> btc_reg)
    else $error("byte done cleared out of order");
  first_byte_a: assert property (
    en_reg && wr_data && !shift_full_reg && !evt.start_sent
    && !evt.stop_sent |=> tx_load && tx_empty_reg
    && tx_byte == $past(bus.wdata[7:0]))
    else $error("first byte not moved to shift");
  tx_park_a: assert property (
    en_reg && wr_data && shift_full_reg && !evt.tx_take && !wr_cfg
    |=> !tx_empty_reg ##1 !tx_empty_reg || evt.tx_take || $past(evt.tx_take)
    || !en_reg || $past(evt.start_sent || evt.stop_sent))
    else $error("tx empty not cleared on parked byte");
  err_w0_a: assert property (
    en_reg && wr_err && !bus.wdata[`ISF_ES_ACK_FAULT] && !evt.ack_missing
    && !wr_cfg |=> !err_reg[`ISF_ES_ACK_FAULT])
    else $error("ack fault not cleared by zero");
  ovr_gate_a: assert property (
    !stretch_disable_reg && !wr_cfg && !err_reg[`ISF_ES_OVR_UNR]
    |=> !err_reg[`ISF_ES_OVR_UNR])
    else $error("over/underrun set while stretching");
  disable_clr_a: assert property (
    !en_reg && !wr_cfg |=> btc_reg == 1'b0 && err_reg == 6'h00
    && tx_empty_reg == 1'b0 && rx_full_reg == 1'b0)
    else $error("flags not clear while disabled");
  arb_slave_a: assert property (
    en_reg && master_reg && evt.arb_lost && !wr_cfg
    |=> !master_mode && err_reg[`ISF_ES_ARB_LOST])
    else $error("arbitration loss not handled");
  irq_a: assert property (
    errie_reg && en_reg && evt.ack_missing && !wr_cfg && !wr_irq
    |=> err_irq)
    else $error("error interrupt not raised");

  rx_overrun_c: cover property (ovr_evt ##1 err_reg[`ISF_ES_OVR_UNR]);
  tx_underrun_c: cover property (unr_evt ##1 tx_load);
  btc_seq_c: cover property (btc_reg && rd_xs ##[1:4] rd_data ##1 !btc_reg);

endmodule

// *** pkg/isf_params.svh ***
// offsets, field positions and reset values of the status flag block
`ifndef ISF_PARAMS_SVH
`define ISF_PARAMS_SVH

// register byte offsets
`define ISF_OFF_CONFIG     8'h00
`define ISF_OFF_CTRL_TWO   8'h04
`define ISF_OFF_DATA       8'h18
`define ISF_OFF_XFER_STS   8'h1C
`define ISF_OFF_ERR_STS    8'h20
`define ISF_OFF_IRQ_CTRL   8'h28

// config register fields
`define ISF_CFG_ENABLE     0
`define ISF_CFG_STRETCH_DISABLE     1

// transfer_status fields
`define ISF_XS_BYTE_DONE   2
`define ISF_XS_HDR10       3
`define ISF_XS_STOP_SEEN   4
`define ISF_XS_RX_FULL     6
`define ISF_XS_TX_EMPTY    7

// error_status fields
`define ISF_ES_BUS_FAULT   0
`define ISF_ES_ARB_LOST    1
`define ISF_ES_ACK_FAULT   2
`define ISF_ES_OVR_UNR     3
`define ISF_ES_HALT_WAKE   5

// interrupt control fields
`define ISF_IC_ERR_EN      0

// reset values
`define ISF_RST_WORD       32'h0000_0000
`define ISF_RST_BYTE       8'h00
`define ISF_RST_ERR        6'h00

`endif

// *** pkg/isf_pkg.sv ***
// types shared by the status flag block and its neighbours
package isf_pkg;

  // register access from software, one strobe per cycle
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } isf_bus_t;

  // one-cycle event pulses from the transfer engine (same clock)
  typedef struct packed {
    logic       rx_arrive;     // a received byte is complete
    logic [7:0] rx_byte;       // byte that came with rx_arrive
    logic       tx_take;       // shift register wants its next byte
    logic       start_sent;    // start condition transmitted
    logic       stop_sent;     // stop condition transmitted
    logic       hdr10_sent;    // 10-bit address header sent
    logic       stop_detected; // stop condition seen on the bus
    logic       bus_misplaced; // start or stop at an illegal point
    logic       arb_lost;      // arbitration lost as master
    logic       ack_missing;   // expected acknowledge not received
    logic       halt_wakeup;   // interface woke the chip from halt
  } isf_evt_t;

endpackage

// *** dv/isf_bus_peer.sv ***
// behavioural transfer engine that raises event pulses for the flag block
`timescale 1ns/1ps

module isf_bus_peer
  import isf_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       go,
  input  wire logic [3:0] sel,
  input  wire logic [7:0] dat,
  output isf_evt_t        evt
);
  logic [9:0] p;

  // ****************
  // event pulses
  // ****************
  // one pulse per request; idle byte lane flips so stale data never looks
  // like a fresh byte
  assign p = go ? (10'h001 << sel) : 10'h000;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      evt <= '0;
    end else begin
      evt <= '{rx_arrive: p[0], rx_byte: (go ? dat : ~evt.rx_byte),
               tx_take: p[1], start_sent: p[2], stop_sent: p[3],
               hdr10_sent: p[4], stop_detected: p[5],
               bus_misplaced: p[6], arb_lost: p[7], ack_missing: p[8],
               halt_wakeup: p[9]};
    end
  end
endmodule

// *** dv/tb_top.sv ***
// self-checking bench for the i2c status flag block
`timescale 1ns/1ps
`include "isf_params.svh"

module tb_top
  import isf_pkg::*;
;
  localparam logic [7:0] A_CFG = `ISF_OFF_CONFIG;
  localparam logic [7:0] A_C2  = `ISF_OFF_CTRL_TWO;
  localparam logic [7:0] A_DAT = `ISF_OFF_DATA;
  localparam logic [7:0] A_XS  = `ISF_OFF_XFER_STS;
  localparam logic [7:0] A_ES  = `ISF_OFF_ERR_STS;
  localparam logic [7:0] A_IC  = `ISF_OFF_IRQ_CTRL;
  localparam logic [3:0] E_RX = 4'h0, E_TK = 4'h1, E_ST = 4'h2;
  localparam logic [3:0] E_SP = 4'h3, E_HD = 4'h4, E_SD = 4'h5;
  localparam logic [3:0] E_BM = 4'h6, E_AL = 4'h7, E_AK = 4'h8;
  localparam logic [3:0] E_HW = 4'h9;

  logic        mclk  = 1'b0;
  logic        rst_n = 1'b0;
  logic        go    = 1'b0;
  logic [3:0]  sel   = 4'h0;
  logic [7:0]  dat   = 8'h00;
  isf_bus_t    bus   = '0;
  isf_evt_t    evt;
  logic [31:0] rdata;
  logic        tx_load, scl_hold, master_mode, err_irq;
  logic [7:0]  tx_byte, last_tx;
  logic [31:0] seed  = 32'hB7FE;
  int          mismatches = 0;
  int          cmp_count  = 0;
  int          loads      = 0;

  always #2 mclk = ~mclk;

  isf_status_flags isf_status_flags_inst (.mclk(mclk), .rst_n(rst_n),
    .bus(bus), .rdata(rdata), .evt(evt), .tx_load(tx_load),
    .tx_byte(tx_byte), .scl_hold(scl_hold), .master_mode(master_mode),
    .err_irq(err_irq));

  isf_bus_peer isf_bus_peer_inst (.mclk(mclk), .rst_n(rst_n), .go(go),
    .sel(sel), .dat(dat), .evt(evt));

  // count shift loads mid-cycle, where the one-cycle pulse is settled
  always @(negedge mclk) begin
    if (tx_load === 1'b1) begin
      loads++;
      last_tx = tx_byte;
    end
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // error bits survive a write only where the written bit is one
  function automatic logic [31:0] err_keep(input logic [31:0] cur, w);
    return cur & w & 32'h0000_002F;
  endfunction

  task automatic chk(input string nm, input logic [31:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge mclk);
    bus.wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rchk(input string nm, input logic [7:0] a,
                      input logic [31:0] e, m);
    @(posedge mclk);
    bus <= '{a, bus.wdata, 1'b0, 1'b1};
    @(posedge mclk);
    bus.rd <= 1'b0;
    #1 chk(nm, rdata & m, e);
  endtask

  task automatic ev(input logic [3:0] k, input logic [7:0] d);
    @(posedge mclk);
    go  <= 1'b1;
    sel <= k;
    dat <= d;
    @(posedge mclk);
    go <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask

  task automatic done(input string s);
    $display("test %s done", s);
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // watchdog: the sequence needs a few hundred cycles at most
  initial begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    $display("watchdog expired");
    final_report();
  end

  initial begin
    logic [31:0] w, e;
    logic [7:0]  a, b, c, d;
    int          n;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    ev(E_BM, 8'h00);
    rchk("err_off", A_ES, 0, '1);
    rchk("unmapped", 8'h3C, 0, '1);
    done("disabled");
    wr(A_CFG, 32'h1);
    for (int i = 0; i < 6; i++) begin
      ev(E_ST, 8'h00);
      chk("mst_on", master_mode, 1);
      ev(E_AL, 8'h00);
      chk("mst_off", master_mode, 0);
      ev(E_BM, 8'h00);
      ev(E_AK, 8'h00);
      ev(E_HW, 8'h00);
      wr(A_IC, 32'(i & 1));
      rchk("err_set", A_ES, 32'h27, '1);
      chk("irq_on", err_irq, 32'(i & 1));
      w = xs();
      e = err_keep(32'h27, w);
      wr(A_ES, w);
      rchk("err_clr", A_ES, e, '1);
      chk("irq_clr", err_irq, 32'((i & 1) && e[3:0] != 0));
    end
    wr(A_ES, 0);
    done("errors");
    a = 8'(xs());
    b = 8'(xs());
    ev(E_RX, a);
    rchk("rx_full", A_XS, 32'h40, '1);
    ev(E_RX, b);
    rchk("rx_late", A_XS, 32'h44, '1);
    rchk("no_ovr", A_ES, 0, '1);
    rchk("rx_a", A_DAT, 32'(a), '1);
    rchk("no_clr", A_XS, 32'h44, '1);
    rchk("rx_b", A_DAT, 32'(b), '1);
    rchk("rx_clr", A_XS, 0, '1);
    wr(A_CFG, 32'h3);
    ev(E_RX, a);
    ev(E_RX, b);
    rchk("ovr", A_ES, 32'h08, '1);
    rchk("keep_a", A_DAT, 32'(a), '1);
    rchk("arm", A_XS, 0, '1);
    rchk("drain", A_DAT, 32'(a), '1);
    rchk("rx_emp", A_XS, 0, 32'h40);
    wr(A_ES, 0);
    wr(A_CFG, 32'h1);
    done("receive");
    c = 8'(xs());
    d = 8'(xs());
    n = loads;
    wr(A_DAT, 32'(c));
    rchk("tx_emp1", A_XS, 32'h80, '1);
    chk("ld1", loads, n + 1);
    chk("tb1", last_tx, c);
    wr(A_DAT, 32'(d));
    rchk("tx_full", A_XS, 0, '1);
    ev(E_TK, 8'h00);
    chk("ld2", loads, n + 2);
    chk("tb2", last_tx, d);
    rchk("tx_emp2", A_XS, 32'h80, '1);
    ev(E_TK, 8'h00);
    rchk("tx_bd", A_XS, 32'h84, '1);
    chk("hold", scl_hold, 1);
    ev(E_ST, 8'h00);
    rchk("st_clr", A_XS, 0, '1);
    ev(E_SP, 8'h00);
    wr(A_CFG, 32'h3);
    n = loads;
    ev(E_TK, 8'h00);
    chk("unr_ld", loads, n + 1);
    chk("unr_b", last_tx, d);
    rchk("unr", A_ES, 32'h08, '1);
    wr(A_ES, 0);
    wr(A_CFG, 32'h1);
    done("transmit");
    ev(E_HD, 8'h00);
    rchk("hdr", A_XS, 32'h08, 32'h08);
    wr(A_DAT, 0);
    rchk("hdr_clr", A_XS, 0, 32'h08);
    ev(E_SD, 8'h00);
    rchk("sd_set", A_XS, 32'h10, 32'h10);
    rchk("disarm", A_ES, 0, '1);
    wr(A_C2, 0);
    rchk("sd_keep", A_XS, 32'h10, 32'h10);
    wr(A_C2, 0);
    rchk("sd_clr", A_XS, 0, 32'h10);
    done("sequences");
    ev(E_BM, 8'h00);
    ev(E_HD, 8'h00);
    wr(A_CFG, 0);
    rchk("off_es", A_ES, 0, '1);
    rchk("off_xs", A_XS, 0, '1);
    done("disable");
    final_report();
  end
endmodule
